// ---- core/bsx_pkg.sv ----
// Package for the byte subtract, exclusive-OR and nibble swap datapath.
package bsx_pkg;
  localparam int BSX_DATA_W = 8;
  localparam int BSX_ADDR_W = 7;
  localparam logic [7:0] BSX_ACC_RST = 8'h00;
  localparam logic BSX_FLAG_RST = 1'b0;
  localparam logic BSX_DEST_ACC = 1'b0;
  localparam logic BSX_DEST_FILE = 1'b1;

  // One-hot operation codes issued by the decoder.
  typedef enum logic [5:0] {
    BSX_OP_NONE = 6'h01,
    BSX_OP_SUB_W_FROM_LITERAL = 6'h02,
    BSX_OP_SUB_W_FROM_FILE = 6'h04,
    BSX_OP_XOR_LITERAL_INTO_ACC = 6'h08,
    BSX_OP_XOR_ACC_WITH_FILE = 6'h10,
    BSX_OP_NIBBLE_SWAP_FILE = 6'h20
  } bsx_op_t;

  // One issued instruction.
  typedef struct packed {
    bsx_op_t op;
    logic [7:0] literal;
    logic [6:0] file_addr;
    logic destination_select;
  } bsx_instr_t;

  // Write-back request toward data memory.
  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } bsx_file_wr_t;

  typedef struct packed {
    logic carry_flag;
    logic digit_carry_flag;
    logic zero_flag;
  } bsx_flags_t;
endpackage : bsx_pkg

// ---- core/bsx_alu.sv ----
// Single-cycle datapath for subtract, exclusive-OR and nibble swap instructions.
// What this block does
// - Literal minus accumulator into accumulator.
// - File minus accumulator into chosen destination.
// - Subtracts set carry, digit carry, zero.
// - Accumulator XOR literal into accumulator.
// - Accumulator XOR file into chosen destination.
// - XORs change only the zero flag.
// - Swap file nibbles into chosen destination.
// - Nibble swap leaves all flags alone.
// - Destination bit picks accumulator or file.
module bsx_alu
  import bsx_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire bsx_instr_t instr,
  input wire logic [7:0] file_rd_data,
  output bsx_file_wr_t file_wr,
  output logic [7:0] acc,
  output bsx_flags_t flags
);
  logic [7:0] acc_r;
  bsx_flags_t flags_r;
  bsx_file_wr_t file_wr_r;

  wire logic is_sub_lit = instr_valid && (instr.op == BSX_OP_SUB_W_FROM_LITERAL);
  wire logic is_sub_file = instr_valid && (instr.op == BSX_OP_SUB_W_FROM_FILE);
  wire logic is_xor_lit = instr_valid && (instr.op == BSX_OP_XOR_LITERAL_INTO_ACC);
  wire logic is_xor_file = instr_valid && (instr.op == BSX_OP_XOR_ACC_WITH_FILE);
  wire logic is_swap = instr_valid && (instr.op == BSX_OP_NIBBLE_SWAP_FILE);
  wire logic is_sub = is_sub_lit || is_sub_file;
  wire logic is_xor = is_xor_lit || is_xor_file;
  wire logic uses_file = is_sub_file || is_xor_file || is_swap;
  wire logic is_ours = is_sub || is_xor || is_swap;

  // Literal forms ignore the destination bit, so they can never reach data memory.
  wire logic [7:0] opnd = (is_sub_lit || is_xor_lit) ? instr.literal : file_rd_data;
  // The ninth bit of operand plus inverted accumulator plus one is the no-borrow carry.
  wire logic [8:0] diff = {1'b0, opnd} + {1'b0, ~acc_r} + 9'h001;
  wire logic [4:0] ldiff = {1'b0, opnd[3:0]} + {1'b0, ~acc_r[3:0]} + 5'h01;
  wire logic [7:0] xres = acc_r ^ opnd;
  wire logic [7:0] sres = {file_rd_data[3:0], file_rd_data[7:4]};
  wire logic [7:0] result = is_sub ? diff[7:0] : (is_xor ? xres : sres);
  wire logic to_file = uses_file && (instr.destination_select == BSX_DEST_FILE);
  wire logic to_acc = is_ours && !to_file;
  wire logic zero = (result == 8'h00);

  // All effects land on the edge closing the instruction cycle.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      acc_r <= BSX_ACC_RST;
    end else if (to_acc) begin
      acc_r <= result;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flags_r <= '{BSX_FLAG_RST, BSX_FLAG_RST, BSX_FLAG_RST};
    end else if (is_sub) begin
      flags_r <= '{diff[8], ldiff[4], zero};
    end else if (is_xor) begin
      flags_r.zero_flag <= zero;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      file_wr_r <= '0;
    end else begin
      file_wr_r <= '{to_file, instr.file_addr, result};
    end
  end

  assign acc = acc_r;
  assign flags = flags_r;
  assign file_wr = file_wr_r;

  property p_sub_carry;
    @(posedge mclk) disable iff (!arst_n)
      is_sub |=> flags_r.carry_flag == ($past(acc_r) <= $past(opnd));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("carry wrong");

  property p_sub_dc;
    @(posedge mclk) disable iff (!arst_n)
      is_sub |=> flags_r.digit_carry_flag == ($past(acc_r[3:0]) <= $past(opnd[3:0]));
  endproperty
  a_sub_dc: assert property (p_sub_dc) else $error("digit carry wrong");

  property p_sub_lit;
    @(posedge mclk) disable iff (!arst_n)
      is_sub_lit |=> acc_r == 8'($past(instr.literal) - $past(acc_r));
  endproperty
  a_sub_lit: assert property (p_sub_lit) else $error("literal subtract wrong");

  property p_sub_file_wr;
    @(posedge mclk) disable iff (!arst_n)
      is_sub_file && instr.destination_select |=>
        file_wr_r.we && file_wr_r.data == 8'($past(file_rd_data) - $past(acc_r));
  endproperty
  a_sub_file_wr: assert property (p_sub_file_wr) else $error("file subtract wrong");

  property p_sub_file_acc;
    @(posedge mclk) disable iff (!arst_n)
      is_sub_file && !instr.destination_select |=>
        acc_r == 8'($past(file_rd_data) - $past(acc_r));
  endproperty
  a_sub_file_acc: assert property (p_sub_file_acc) else $error("subtract to acc wrong");

  property p_xor_lit;
    @(posedge mclk) disable iff (!arst_n)
      is_xor_lit |=> acc_r == ($past(acc_r) ^ $past(instr.literal));
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("literal xor wrong");

  property p_xor_file;
    @(posedge mclk) disable iff (!arst_n)
      is_xor_file && !instr.destination_select |=>
        acc_r == ($past(acc_r) ^ $past(file_rd_data));
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("file xor wrong");

  property p_xor_file_wr;
    @(posedge mclk) disable iff (!arst_n)
      is_xor_file && instr.destination_select |=>
        file_wr_r.we && file_wr_r.data == ($past(acc_r) ^ $past(file_rd_data));
  endproperty
  a_xor_file_wr: assert property (p_xor_file_wr) else $error("xor to file wrong");

  property p_xor_flags;
    @(posedge mclk) disable iff (!arst_n)
      is_xor |=> $stable(flags_r.carry_flag) && $stable(flags_r.digit_carry_flag);
  endproperty
  a_xor_flags: assert property (p_xor_flags) else $error("xor touched carry");

  property p_swap;
    @(posedge mclk) disable iff (!arst_n)
      is_swap && instr.destination_select |=>
        file_wr_r.data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])};
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");

  property p_swap_acc;
    @(posedge mclk) disable iff (!arst_n)
      is_swap && !instr.destination_select |=>
        acc_r == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])};
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("swap to acc wrong");

  property p_swap_flags;
    @(posedge mclk) disable iff (!arst_n)
      is_swap |=> $stable(flags_r);
  endproperty
  a_swap_flags: assert property (p_swap_flags) else $error("swap touched flags");

  property p_dest_acc;
    @(posedge mclk) disable iff (!arst_n)
      uses_file && !instr.destination_select |=> !file_wr_r.we;
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("file written for d=0");

  // A result sent to data memory must not also disturb the accumulator.
  property p_file_keeps_acc;
    @(posedge mclk) disable iff (!arst_n)
      to_file |=> $stable(acc_r);
  endproperty
  a_file_keeps_acc: assert property (p_file_keeps_acc) else $error("acc moved on file write");

  property p_file_addr;
    @(posedge mclk) disable iff (!arst_n)
      to_file |=> file_wr_r.addr == $past(instr.file_addr);
  endproperty
  a_file_addr: assert property (p_file_addr) else $error("write address wrong");

  property p_lit_no_file;
    @(posedge mclk) disable iff (!arst_n)
      (is_sub_lit || is_xor_lit) |=> !file_wr_r.we;
  endproperty
  a_lit_no_file: assert property (p_lit_no_file) else $error("literal op wrote file");

  property p_zero;
    @(posedge mclk) disable iff (!arst_n)
      (is_sub || is_xor) |=> flags_r.zero_flag == ($past(result) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  sequence s_no_instr;
    !instr_valid;
  endsequence
  property p_one_cycle;
    @(posedge mclk) disable iff (!arst_n)
      s_no_instr |=> !file_wr_r.we && $stable(acc_r) ##1 1'b1;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("effect without instruction");

  // The write strobe is a single pulse; a held strobe would write memory twice.
  property p_we_pulse;
    @(posedge mclk) disable iff (!arst_n)
      !to_file |=> !file_wr_r.we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe held");

  property p_idle_flags;
    @(posedge mclk) disable iff (!arst_n)
      s_no_instr |=> $stable(flags_r);
  endproperty
  a_idle_flags: assert property (p_idle_flags) else $error("flags moved when idle");
endmodule : bsx_alu

// ---- verification/tb_top.sv ----
// Self-checking random bench for the subtract, exclusive-OR and swap datapath.
module tb_top
  import bsx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  bsx_instr_t instr = '0;
  logic [7:0] file_rd_data = 8'h00;
  bsx_file_wr_t file_wr;
  logic [7:0] acc;
  bsx_flags_t flags;
  logic [7:0] acc_m = 8'h00;
  bsx_flags_t flg_m = '0;
  logic we_m = 1'b0;
  logic [7:0] data_m;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  bsx_op_t ops [6] = '{BSX_OP_NONE, BSX_OP_SUB_W_FROM_LITERAL, BSX_OP_SUB_W_FROM_FILE,
    BSX_OP_XOR_LITERAL_INTO_ACC, BSX_OP_XOR_ACC_WITH_FILE, BSX_OP_NIBBLE_SWAP_FILE};

  bsx_alu DUT (.mclk(mclk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
    .file_rd_data(file_rd_data), .file_wr(file_wr), .acc(acc), .flags(flags));

  always #50 mclk = ~mclk;

  // The ceiling sits well above the thousand steps the sequence needs.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] ref_result(bsx_op_t op, logic [7:0] opnd, logic [7:0] w);
    case (op)
      BSX_OP_XOR_LITERAL_INTO_ACC, BSX_OP_XOR_ACC_WITH_FILE: return w ^ opnd;
      BSX_OP_NIBBLE_SWAP_FILE: return {opnd[3:0], opnd[7:4]};
      default: return opnd - w;
    endcase
  endfunction : ref_result

  task automatic check8(string name, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check8

  task automatic step(logic v, bsx_op_t op, logic [7:0] lit, logic [6:0] a, logic d,
      logic [7:0] f);
    logic file_op;
    logic [7:0] opnd;
    logic [7:0] r;
    file_op = op inside {BSX_OP_SUB_W_FROM_FILE, BSX_OP_XOR_ACC_WITH_FILE,
      BSX_OP_NIBBLE_SWAP_FILE};
    opnd = file_op ? f : lit;
    r = ref_result(op, opnd, acc_m);
    instr_valid = v;
    instr = '{op: op, literal: lit, file_addr: a, destination_select: d};
    file_rd_data = f;
    we_m = v && file_op && d;
    data_m = r;
    if (v && op != BSX_OP_NONE) begin
      if (op inside {BSX_OP_SUB_W_FROM_LITERAL, BSX_OP_SUB_W_FROM_FILE}) begin
        flg_m.carry_flag = acc_m <= opnd;
        flg_m.digit_carry_flag = acc_m[3:0] <= opnd[3:0];
      end
      if (op != BSX_OP_NIBBLE_SWAP_FILE) flg_m.zero_flag = r == 8'h00;
      if (!we_m) acc_m = r;
    end
    @(posedge mclk);
    #1;
    check8("acc", acc_m, acc);
    check8("flags", {5'h00, flg_m}, {5'h00, flags});
    check8("we", {7'h00, we_m}, {7'h00, file_wr.we});
    if (we_m) begin
      check8("addr", {1'b0, a}, {1'b0, file_wr.addr});
      check8("wdata", data_m, file_wr.data);
    end
  endtask : step

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish

  initial begin
    logic [7:0] f;
    void'($urandom(78));
    repeat (6) @(posedge mclk);
    check8("acc_rst", BSX_ACC_RST, acc);
    check8("flags_rst", 8'h00, {5'h00, flags});
    #1 arst_n = 1'b1;
    $display("test reset done");
    // Zero results, a borrow from the high nibble only and writes back to the file.
    step(1'b1, BSX_OP_SUB_W_FROM_LITERAL, 8'h00, 7'h00, 1'b0, 8'h00);
    step(1'b1, BSX_OP_XOR_LITERAL_INTO_ACC, 8'h5A, 7'h7F, 1'b1, 8'h00);
    step(1'b1, BSX_OP_SUB_W_FROM_FILE, 8'h00, 7'h7F, 1'b0, 8'h4B);
    step(1'b1, BSX_OP_NIBBLE_SWAP_FILE, 8'h00, 7'h11, 1'b1, 8'h3C);
    step(1'b1, BSX_OP_XOR_ACC_WITH_FILE, 8'h00, 7'h22, 1'b0, 8'hF1);
    step(1'b0, BSX_OP_SUB_W_FROM_FILE, 8'hFF, 7'h33, 1'b1, 8'h00);
    step(1'b1, BSX_OP_SUB_W_FROM_FILE, 8'hFF, 7'h33, 1'b1, 8'hFF);
    $display("test corners done");
    repeat (1000) begin
      f = ($urandom % 4 == 0) ? acc_m : 8'($urandom);
      step(1'($urandom % 8 != 0), ops[$urandom % 6], ($urandom % 4 == 0) ? acc_m :
        8'($urandom), 7'($urandom), 1'($urandom), f);
    end
    $display("test random done");
    tally_and_finish();
  end
endmodule : tb_top
